// [verilog/controller_status_flag_word.sv]
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module controller_status_flag_word #(
	parameter int unsigned TICK_CYC = status_word_pkg::TIMEBASE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	// wishbone classic slave
	input wire logic cyc,
	input wire logic stb,
	input wire logic we,
	input wire logic [7:0] adr,
	input wire logic [3:0] sel,
	input wire logic [31:0] dat_w,
	output logic [31:0] dat_r,
	output logic ack,
	// controller core events
	input wire logic sys_init,
	input wire logic self_diag_err,
	input wire logic [15:0] diag_code,
	input wire logic cassette_io_err,
	input wire logic cassette_err,
	input wire logic io_verify_err,
	input wire logic battery_low,
	input wire logic op_err,
	input wire logic [15:0] op_addr,
	input wire logic arith_valid,
	input wire logic arith_carry,
	input wire logic arith_zero,
	input wire logic shift_valid,
	input wire logic shift_bit,
	input wire logic cmp_valid,
	input wire logic [15:0] cmp_a,
	input wire logic [15:0] cmp_b,
	input wire logic aux_trig,
	input wire logic [15:0] aux_preset,
	input wire logic tool_port_err,
	input wire logic scan_start
);

	// ----------------------------------------
	// flag registers
	// ----------------------------------------
	logic self_diag_error_flag_reg;
	logic cassette_io_error_flag_reg;
	logic cassette_fault_flag_reg;
	logic io_verify_error_flag_reg;
	logic battery_error_live_reg;
	logic battery_error_sticky_reg;
	logic op_error_sticky_reg;
	logic op_error_momentary_reg;
	logic carry_flag_reg;
	logic greater_than_flag_reg;
	logic equal_flag_reg;
	logic less_than_flag_reg;
	logic tool_port_error_flag_reg;
	logic scan_overrun_flag_reg;
	logic [15:0] diag_error_code_word_reg;
	logic [15:0] first_error_address_word_reg;
	logic [15:0] latest_error_address_word_reg;
	logic [31:0] scan_ctrl_reg;
	logic [21:0] tick_cnt_reg;
	logic [15:0] aux_remain_reg;
	logic [15:0] aux_remain_next;
	status_word_pkg::aux_state_t aux_state_reg;
	status_word_pkg::aux_state_t aux_state_next;
	logic [15:0] scan_len_reg;
	logic scan_seen_reg;
	logic [31:0] dat_r_next;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire logic req = cyc & stb & ~ack;
	wire logic wr_req = req & we;
	wire logic hit_status = adr == status_word_pkg::OFS_STATUS;
	wire logic hit_diag = adr == status_word_pkg::OFS_DIAG_CODE;
	wire logic hit_first = adr == status_word_pkg::OFS_FIRST_ADDR;
	wire logic hit_latest = adr == status_word_pkg::OFS_LATEST_ADDR;
	wire logic hit_ctrl = adr == status_word_pkg::OFS_SCAN_CTRL;
	wire logic ctrl_wr = wr_req & hit_ctrl;
	wire logic tick = tick_cnt_reg == 22'(TICK_CYC - 1);
	wire logic [15:0] scan_period = scan_ctrl_reg[status_word_pkg::SCAN_PERIOD_LSB +:
		status_word_pkg::SCAN_PERIOD_W];
	wire logic const_scan_en = scan_ctrl_reg[status_word_pkg::SCAN_EN_BIT];
	wire logic scan_late = scan_start & scan_seen_reg & (scan_len_reg > scan_period);
	wire logic scan_over_set = const_scan_en & ((scan_period == 16'h0000) | scan_late);
	wire logic cmp_gt = $signed(cmp_a) > $signed(cmp_b);
	wire logic cmp_lt = $signed(cmp_a) < $signed(cmp_b);
	wire logic cmp_eq = cmp_a == cmp_b;
	wire logic aux_timer_done = aux_state_reg == status_word_pkg::AUX_DONE;

	// only the bus reads it; no port carries the word out
	logic [15:0] special_status_word_0;
	always_comb begin
		special_status_word_0 = 16'h0000;
		special_status_word_0[status_word_pkg::BIT_SELF_DIAG] = self_diag_error_flag_reg;
		special_status_word_0[status_word_pkg::BIT_UNUSED] = 1'b0;
		special_status_word_0[status_word_pkg::BIT_CASS_IO] = cassette_io_error_flag_reg;
		special_status_word_0[status_word_pkg::BIT_CASS_FAULT] = cassette_fault_flag_reg;
		special_status_word_0[status_word_pkg::BIT_IO_VERIFY] = io_verify_error_flag_reg;
		special_status_word_0[status_word_pkg::BIT_BATT_LIVE] = battery_error_live_reg;
		special_status_word_0[status_word_pkg::BIT_BATT_STICKY] = battery_error_sticky_reg;
		special_status_word_0[status_word_pkg::BIT_OP_STICKY] = op_error_sticky_reg;
		special_status_word_0[status_word_pkg::BIT_OP_MOMENT] = op_error_momentary_reg;
		special_status_word_0[status_word_pkg::BIT_CARRY] = carry_flag_reg;
		special_status_word_0[status_word_pkg::BIT_GREATER] = greater_than_flag_reg;
		special_status_word_0[status_word_pkg::BIT_EQUAL] = equal_flag_reg;
		special_status_word_0[status_word_pkg::BIT_LESS] = less_than_flag_reg;
		special_status_word_0[status_word_pkg::BIT_AUX_DONE] = aux_timer_done;
		special_status_word_0[status_word_pkg::BIT_TOOL_PORT] = tool_port_error_flag_reg;
		special_status_word_0[status_word_pkg::BIT_SCAN_OVER] = scan_overrun_flag_reg;
	end

	// unmapped addresses answer zero; status writes are dropped
	assign dat_r_next = hit_status ? {16'h0000, special_status_word_0} :
		hit_diag ? {16'h0000, diag_error_code_word_reg} :
		hit_first ? {16'h0000, first_error_address_word_reg} :
		hit_latest ? {16'h0000, latest_error_address_word_reg} :
		hit_ctrl ? {15'h0000, scan_ctrl_reg[16:0]} : 32'h0000_0000;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack <= req;
			dat_r <= (req & ~we) ? dat_r_next : dat_r;
		end
	end

	// per-lane next value; lane 2 keeps only the enable bit, the rest read zero
	wire logic [23:0] scan_ctrl_next;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ctrl_lane
			wire logic [7:0] lane_data = (gi == 2) ? {7'h00, dat_w[16]} : dat_w[gi*8 +: 8];
			assign scan_ctrl_next[gi*8 +: 8] = (ctrl_wr & sel[gi]) ? lane_data :
				scan_ctrl_reg[gi*8 +: 8];
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scan_ctrl_reg <= status_word_pkg::SCAN_CTRL_RST;
		end else begin
			scan_ctrl_reg <= {8'h00, scan_ctrl_next};
		end
	end

	// ----------------------------------------
	// error flags
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			self_diag_error_flag_reg <= 1'b0;
			diag_error_code_word_reg <= status_word_pkg::WORD16_RST;
			cassette_io_error_flag_reg <= 1'b0;
			cassette_fault_flag_reg <= 1'b0;
			io_verify_error_flag_reg <= 1'b0;
			tool_port_error_flag_reg <= 1'b0;
			battery_error_live_reg <= 1'b0;
			battery_error_sticky_reg <= 1'b0;
		end else begin
			// set wins over init in the same cycle
			self_diag_error_flag_reg <= self_diag_err | (self_diag_error_flag_reg & ~sys_init);
			if (self_diag_err) begin
				diag_error_code_word_reg <= diag_code;
			end
			cassette_io_error_flag_reg <= cassette_io_err;
			cassette_fault_flag_reg <= cassette_err | cassette_io_err;
			io_verify_error_flag_reg <= io_verify_err;
			tool_port_error_flag_reg <= tool_port_err;
			// no reporting mask gates either battery flag
			battery_error_live_reg <= battery_low;
			battery_error_sticky_reg <= battery_low | (battery_error_sticky_reg & ~sys_init);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			op_error_sticky_reg <= 1'b0;
			op_error_momentary_reg <= 1'b0;
			first_error_address_word_reg <= status_word_pkg::WORD16_RST;
			latest_error_address_word_reg <= status_word_pkg::WORD16_RST;
		end else begin
			op_error_sticky_reg <= op_err | (op_error_sticky_reg & ~sys_init);
			op_error_momentary_reg <= op_err;
			// an init clears the hold, so the next error counts as first again
			if (op_err & (~op_error_sticky_reg | sys_init)) begin
				first_error_address_word_reg <= op_addr;
			end
			if (op_err) begin
				latest_error_address_word_reg <= op_addr;
			end
		end
	end

	// ----------------------------------------
	// arithmetic and compare flags
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			carry_flag_reg <= 1'b0;
			greater_than_flag_reg <= 1'b0;
			equal_flag_reg <= 1'b0;
			less_than_flag_reg <= 1'b0;
		end else begin
			// shift result takes priority if both arrive together
			if (shift_valid) begin
				carry_flag_reg <= shift_bit;
			end else if (arith_valid) begin
				carry_flag_reg <= arith_carry;
			end
			greater_than_flag_reg <= cmp_valid & cmp_gt;
			equal_flag_reg <= (cmp_valid & cmp_eq) | (arith_valid & arith_zero);
			less_than_flag_reg <= cmp_valid & cmp_lt;
		end
	end

	// ----------------------------------------
	// timebase and auxiliary timer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_reg <= 22'h00_0000;
		end else begin
			tick_cnt_reg <= tick ? 22'h00_0000 : tick_cnt_reg + 22'h00_0001;
		end
	end

	always_comb begin
		aux_state_next = aux_state_reg;
		aux_remain_next = aux_remain_reg;
		case (aux_state_reg)
			status_word_pkg::AUX_IDLE: begin
				if (aux_trig) begin
					aux_remain_next = aux_preset;
					aux_state_next = (aux_preset == 16'h0000) ? status_word_pkg::AUX_DONE :
						status_word_pkg::AUX_RUN;
				end
			end
			status_word_pkg::AUX_RUN: begin
				if (!aux_trig) begin
					aux_state_next = status_word_pkg::AUX_IDLE;
				end else if (tick) begin
					aux_remain_next = aux_remain_reg - 16'h0001;
					if (aux_remain_reg == 16'h0001) begin
						aux_state_next = status_word_pkg::AUX_DONE;
					end
				end
			end
			status_word_pkg::AUX_DONE: begin
				if (!aux_trig) begin
					aux_state_next = status_word_pkg::AUX_IDLE;
				end
			end
			default: begin
				aux_state_next = status_word_pkg::AUX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aux_state_reg <= status_word_pkg::AUX_IDLE;
			aux_remain_reg <= status_word_pkg::WORD16_RST;
		end else begin
			aux_state_reg <= aux_state_next;
			aux_remain_reg <= aux_remain_next;
		end
	end

	// ----------------------------------------
	// constant scan supervision
	// ----------------------------------------
	// first boundary only arms; no full scan measured before it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scan_len_reg <= status_word_pkg::WORD16_RST;
			scan_seen_reg <= 1'b0;
			scan_overrun_flag_reg <= 1'b0;
		end else begin
			if (scan_start) begin
				scan_len_reg <= 16'h0000;
				scan_seen_reg <= 1'b1;
			end else if (tick & (scan_len_reg != 16'hFFFF)) begin
				scan_len_reg <= scan_len_reg + 16'h0001;
			end
			scan_overrun_flag_reg <= scan_over_set | (scan_overrun_flag_reg & ~sys_init);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	localparam int ACK_MIN = 1;
	localparam int ACK_MAX = 1;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	status_ro_a: assert property (wr_req & hit_status & ~self_diag_err |=>
		$stable(diag_error_code_word_reg))
		else $error("status write disturbed the diagnostic code");
	diag_code_a: assert property (self_diag_err |=> self_diag_error_flag_reg &&
		diag_error_code_word_reg == $past(diag_code))
		else $error("diagnostic error not captured");
	cassette_flags_a: assert property (cassette_io_err |=> special_status_word_0[3:2] == 2'b11)
		else $error("cassette flags missing");
	cassette_fault_a: assert property (cassette_err |=> cassette_fault_flag_reg)
		else $error("cassette fault flag missing");
	verify_flag_a: assert property (io_verify_err |=> io_verify_error_flag_reg)
		else $error("verify flag missing");
	battery_live_a: assert property (1'b1 |=> battery_error_live_reg == $past(battery_low))
		else $error("live battery flag lags");
	battery_hold_a: assert property (battery_error_sticky_reg && !sys_init |=>
		battery_error_sticky_reg)
		else $error("held battery flag dropped");
	battery_set_a: assert property (battery_low |=> battery_error_sticky_reg)
		else $error("held battery flag not set");
	battery_clear_a: assert property ($fell(battery_error_sticky_reg) |-> $past(sys_init))
		else $error("held battery flag cleared without init");
	first_addr_a: assert property (op_error_sticky_reg && !sys_init |=>
		$stable(first_error_address_word_reg))
		else $error("first error address overwritten");
	op_moment_a: assert property (op_err ##1 !op_err |=> !op_error_momentary_reg)
		else $error("momentary op flag held");
	latest_addr_a: assert property (op_err |=> latest_error_address_word_reg == $past(op_addr))
		else $error("latest error address not updated");
	op_first_a: assert property (op_err && (!op_error_sticky_reg || sys_init) |=>
		first_error_address_word_reg == $past(op_addr))
		else $error("first error address not captured");
	carry_arith_a: assert property (arith_valid && !shift_valid |=>
		carry_flag_reg == $past(arith_carry))
		else $error("carry not from arithmetic");
	carry_shift_a: assert property (shift_valid |=> carry_flag_reg == $past(shift_bit))
		else $error("carry not from shift");
	greater_pulse_a: assert property (cmp_valid && cmp_gt |=>
		greater_than_flag_reg && !less_than_flag_reg)
		else $error("greater flag wrong");
	equal_pulse_a: assert property (arith_valid && arith_zero |=> equal_flag_reg)
		else $error("equal flag missing on zero result");
	equal_cmp_a: assert property (cmp_valid && cmp_eq |=>
		equal_flag_reg && !greater_than_flag_reg && !less_than_flag_reg)
		else $error("equal flag wrong on compare");
	less_pulse_a: assert property (cmp_valid && cmp_lt |=>
		less_than_flag_reg && !greater_than_flag_reg &&
		equal_flag_reg == $past(arith_valid && arith_zero))
		else $error("less flag wrong");
	cmp_idle_a: assert property (!cmp_valid && !arith_valid |=>
		!greater_than_flag_reg && !equal_flag_reg && !less_than_flag_reg)
		else $error("compare flag held without an event");
	aux_off_a: assert property (!aux_trig |=> !aux_timer_done)
		else $error("aux done held after trigger off");
	aux_zero_a: assert property (aux_state_reg == status_word_pkg::AUX_RUN &&
		aux_trig && tick && aux_remain_reg == 16'h0001 |=> aux_timer_done)
		else $error("aux done missed at zero");
	tool_port_a: assert property (tool_port_err |=> tool_port_error_flag_reg)
		else $error("tool port flag missing");
	scan_late_a: assert property (const_scan_en && scan_late |=> scan_overrun_flag_reg)
		else $error("scan overrun missed");
	scan_zero_a: assert property (const_scan_en && scan_period == 16'h0000 |=>
		scan_overrun_flag_reg)
		else $error("zero period not flagged");
	unused_bit_a: assert property (special_status_word_0[status_word_pkg::BIT_UNUSED] == 1'b0)
		else $error("unused bit set");
	bus_ack_a: assert property (req |-> ##[ACK_MIN:ACK_MAX] ack ##1 !ack)
		else $error("bus answer late or long");
	scan_ctrl_a: assert property (ctrl_wr && sel[2] |=> const_scan_en == $past(dat_w[16]))
		else $error("scan enable write lost");

	op_err_c: cover property (op_err ##1 op_err ##1 !op_err);
	overrun_c: cover property (scan_late && const_scan_en);
	aux_done_c: cover property (aux_timer_done ##1 !aux_timer_done);
	status_read_c: cover property (req && !we && hit_status);
	batt_init_c: cover property (sys_init && battery_error_sticky_reg);

endmodule // controller_status_flag_word
`default_nettype wire

// [verilog/status_word_pkg.sv]
// Functional notes
// - status word is read-only, never driven out
// - self-diagnostic error sets flag, stores code
// - I/O cassette fault raises cassette I/O flag
// - any cassette error raises cassette fault flag
// - I/O verification mismatch raises verify flag
// - live battery flag follows battery, ignores reporting
// - held battery flag stays after recovery
// - held battery flag cleared only by init
// - held op error flag; first address captured once
// - momentary op error flag lasts one instant
// - latest address overwritten on each op error
// - carry set on arithmetic overflow or underflow
// - carry also updated by shift output bit
// - greater flag pulses when first operand larger
// - equal flag pulses on equality or zero result
// - less flag pulses when first operand smaller
// - aux timer done at zero, cleared by trigger off
// - tool port error flag on serial port error
// - scan overrun when scan exceeds constant period
// - scan overrun when constant period set zero
package status_word_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_DIAG_CODE = 8'h04;
	localparam logic [7:0] OFS_FIRST_ADDR = 8'h08;
	localparam logic [7:0] OFS_LATEST_ADDR = 8'h0C;
	localparam logic [7:0] OFS_SCAN_CTRL = 8'h10;

	// ----------------------------------------
	// status word bit positions
	// ----------------------------------------
	localparam int BIT_SELF_DIAG = 0;
	localparam int BIT_UNUSED = 1;
	localparam int BIT_CASS_IO = 2;
	localparam int BIT_CASS_FAULT = 3;
	localparam int BIT_IO_VERIFY = 4;
	localparam int BIT_BATT_LIVE = 5;
	localparam int BIT_BATT_STICKY = 6;
	localparam int BIT_OP_STICKY = 7;
	localparam int BIT_OP_MOMENT = 8;
	localparam int BIT_CARRY = 9;
	localparam int BIT_GREATER = 10;
	localparam int BIT_EQUAL = 11;
	localparam int BIT_LESS = 12;
	localparam int BIT_AUX_DONE = 13;
	localparam int BIT_TOOL_PORT = 14;
	localparam int BIT_SCAN_OVER = 15;

	// ----------------------------------------
	// scan control fields and reset values
	// ----------------------------------------
	localparam int SCAN_PERIOD_LSB = 0;
	localparam int SCAN_PERIOD_W = 16;
	localparam int SCAN_EN_BIT = 16;
	localparam logic [31:0] SCAN_CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] WORD16_RST = 16'h0000;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int TIMEBASE_NS = 10_000_000;
	localparam int TIMEBASE_CYCLES = TIMEBASE_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		AUX_IDLE = 2'b00,
		AUX_RUN = 2'b01,
		AUX_DONE = 2'b10
	} aux_state_t;

endpackage

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ----------------------------------------
	// stimulus and dut
	// ----------------------------------------
	logic clk;
	logic rst_b;
	logic cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_w, dat_r, rdat;
	logic sys_init, self_diag_err, cassette_io_err, cassette_err, io_verify_err, battery_low;
	logic op_err, arith_valid, arith_carry, arith_zero, shift_valid, shift_bit, cmp_valid;
	logic aux_trig, tool_port_err, scan_start;
	logic [15:0] diag_code, op_addr, cmp_a, cmp_b, aux_preset;
	logic [15:0] ca [3] = '{16'h0005, 16'h0003, 16'hFFFF};
	logic [15:0] cbv [3] = '{16'h0003, 16'h0003, 16'h0001};
	int errors = 0;
	int cmp_count = 0;

	controller_status_flag_word #(.TICK_CYC(4)) u_controller_status_flag_word (
		.clk(clk), .rst_b(rst_b), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.dat_w(dat_w), .dat_r(dat_r), .ack(ack), .sys_init(sys_init),
		.self_diag_err(self_diag_err), .diag_code(diag_code),
		.cassette_io_err(cassette_io_err), .cassette_err(cassette_err),
		.io_verify_err(io_verify_err), .battery_low(battery_low), .op_err(op_err),
		.op_addr(op_addr), .arith_valid(arith_valid), .arith_carry(arith_carry),
		.arith_zero(arith_zero), .shift_valid(shift_valid), .shift_bit(shift_bit),
		.cmp_valid(cmp_valid), .cmp_a(cmp_a), .cmp_b(cmp_b), .aux_trig(aux_trig),
		.aux_preset(aux_preset), .tool_port_err(tool_port_err), .scan_start(scan_start));

	always #(status_word_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cb(input string name, input int b, input logic e);
		chk(name, {31'h0000_0000, e}, {31'h0000_0000, rdat[b]});
	endtask

	// pulse inputs drop at the edge that launches the access, so the
	// momentary flags set at that same edge are still caught by it
	task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{sys_init, self_diag_err, op_err, arith_valid, shift_valid} <= 5'h00;
		{cmp_valid, scan_start} <= 2'b00;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		sel <= 4'hF;
		adr <= a;
		dat_w <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		chk("ack", 32'h0000_0001, {31'h0000_0000, ack});
		rdat = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic summarize;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------
	// watchdog, far above the few hundred cycles needed
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		summarize();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		{cyc, stb, we, adr, sel, dat_w} = '0;
		{sys_init, self_diag_err, cassette_io_err, cassette_err, io_verify_err} = '0;
		{battery_low, op_err, arith_valid, arith_carry, arith_zero, shift_valid} = '0;
		{shift_bit, cmp_valid, aux_trig, tool_port_err, scan_start} = '0;
		{diag_code, op_addr, cmp_a, cmp_b, aux_preset} = '0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		// reset values, unmapped address reads zero
		foreach (ca[i]) begin
			rd(8'(i * 4));
			chk("reset word", 32'h0000_0000, rdat);
		end
		rd(8'h10);
		chk("scan ctrl reset", 32'h0000_0000, rdat);
		rd(8'h20);
		chk("unmapped", 32'h0000_0000, rdat);
		// status word cannot be written
		wb(1'b1, 8'h00, 32'hFFFF_FFFF);
		rd(8'h00);
		chk("status after write", 32'h0000_0000, rdat);
		@(posedge clk);
		self_diag_err <= 1'b1;
		diag_code <= 16'h5A3C;
		rd(8'h00);
		cb("self diag", status_word_pkg::BIT_SELF_DIAG, 1'b1);
		rd(8'h04);
		chk("diag code", 32'h0000_5A3C, rdat);
		// live level flags
		@(posedge clk);
		cassette_io_err <= 1'b1;
		rd(8'h00);
		cb("cass io", status_word_pkg::BIT_CASS_IO, 1'b1);
		cb("cass fault", status_word_pkg::BIT_CASS_FAULT, 1'b1);
		@(posedge clk);
		cassette_io_err <= 1'b0;
		cassette_err <= 1'b1;
		rd(8'h00);
		cb("cass io", status_word_pkg::BIT_CASS_IO, 1'b0);
		cb("cass fault", status_word_pkg::BIT_CASS_FAULT, 1'b1);
		@(posedge clk);
		cassette_err <= 1'b0;
		io_verify_err <= 1'b1;
		tool_port_err <= 1'b1;
		rd(8'h00);
		cb("cass fault", status_word_pkg::BIT_CASS_FAULT, 1'b0);
		cb("io verify", status_word_pkg::BIT_IO_VERIFY, 1'b1);
		cb("tool port", status_word_pkg::BIT_TOOL_PORT, 1'b1);
		@(posedge clk);
		io_verify_err <= 1'b0;
		tool_port_err <= 1'b0;
		rd(8'h00);
		cb("io verify", status_word_pkg::BIT_IO_VERIFY, 1'b0);
		cb("tool port", status_word_pkg::BIT_TOOL_PORT, 1'b0);
		// battery: live follows, held survives recovery until init
		@(posedge clk);
		battery_low <= 1'b1;
		rd(8'h00);
		cb("batt live", status_word_pkg::BIT_BATT_LIVE, 1'b1);
		cb("batt held", status_word_pkg::BIT_BATT_STICKY, 1'b1);
		@(posedge clk);
		battery_low <= 1'b0;
		rd(8'h00);
		cb("batt live", status_word_pkg::BIT_BATT_LIVE, 1'b0);
		cb("batt held", status_word_pkg::BIT_BATT_STICKY, 1'b1);
		@(posedge clk);
		sys_init <= 1'b1;
		rd(8'h00);
		chk("status after init", 32'h0000_0000, rdat);
		// operation errors: first address kept, latest overwritten
		@(posedge clk);
		op_err <= 1'b1;
		op_addr <= 16'h0123;
		rd(8'h00);
		cb("op held", status_word_pkg::BIT_OP_STICKY, 1'b1);
		cb("op moment", status_word_pkg::BIT_OP_MOMENT, 1'b1);
		rd(8'h00);
		cb("op held", status_word_pkg::BIT_OP_STICKY, 1'b1);
		cb("op moment", status_word_pkg::BIT_OP_MOMENT, 1'b0);
		@(posedge clk);
		op_err <= 1'b1;
		op_addr <= 16'h0456;
		rd(8'h08);
		chk("first addr", 32'h0000_0123, rdat);
		rd(8'h0C);
		chk("latest addr", 32'h0000_0456, rdat);
		// carry from arithmetic and shift, zero result
		@(posedge clk);
		arith_valid <= 1'b1;
		arith_carry <= 1'b1;
		arith_zero <= 1'b1;
		rd(8'h00);
		cb("carry", status_word_pkg::BIT_CARRY, 1'b1);
		cb("equal", status_word_pkg::BIT_EQUAL, 1'b1);
		foreach (ca[i]) begin
			@(posedge clk);
			shift_valid <= 1'b1;
			shift_bit <= i[0];
			rd(8'h00);
			cb("carry shift", status_word_pkg::BIT_CARRY, i[0]);
			cb("equal", status_word_pkg::BIT_EQUAL, 1'b0);
		end
		// compares, operands signed
		foreach (ca[i]) begin
			@(posedge clk);
			cmp_valid <= 1'b1;
			cmp_a <= ca[i];
			cmp_b <= cbv[i];
			rd(8'h00);
			cb("greater", status_word_pkg::BIT_GREATER, i == 0);
			cb("equal", status_word_pkg::BIT_EQUAL, i == 1);
			cb("less", status_word_pkg::BIT_LESS, i == 2);
		end
		// aux timer: 3 ticks of 4 cycles
		@(posedge clk);
		aux_preset <= 16'h0003;
		aux_trig <= 1'b1;
		rd(8'h00);
		cb("aux done", status_word_pkg::BIT_AUX_DONE, 1'b0);
		repeat (30) @(posedge clk);
		rd(8'h00);
		cb("aux done", status_word_pkg::BIT_AUX_DONE, 1'b1);
		aux_trig <= 1'b0;
		rd(8'h00);
		cb("aux done", status_word_pkg::BIT_AUX_DONE, 1'b0);
		// constant scan: in time, overrun, then period zero
		foreach (cbv[i]) begin
			if (i < 2) begin
				wb(1'b1, 8'h10, (i == 0) ? 32'h0001_000A : 32'h0001_0002);
				rd(8'h10);
				chk("scan ctrl", (i == 0) ? 32'h0001_000A : 32'h0001_0002, rdat);
				@(posedge clk);
				scan_start <= 1'b1;
				@(posedge clk);
				scan_start <= 1'b0;
				repeat (19) @(posedge clk);
				scan_start <= 1'b1;
				rd(8'h00);
				cb("scan over", status_word_pkg::BIT_SCAN_OVER, i == 1);
			end
		end
		@(posedge clk);
		sys_init <= 1'b1;
		rd(8'h00);
		cb("scan over", status_word_pkg::BIT_SCAN_OVER, 1'b0);
		wb(1'b1, 8'h10, 32'h0001_0000);
		rd(8'h00);
		cb("scan over", status_word_pkg::BIT_SCAN_OVER, 1'b1);
		cb("unused bit", status_word_pkg::BIT_UNUSED, 1'b0);
		summarize();
	end
endmodule // tb
`default_nettype wire
